// >>> logic/pib_bridge.v
// Purpose: slot-bus side pin behaviour of a PCI-to-slot-bus bridge
// Assumes: all inputs except SERIAL_LINK_CLOCK_I (sampled) synchronous to CLK_SYS_I; SRST_I is the bridge reset
// Notes: cycle requests are queued in a 16-entry FIFO
// Summary of operation
// - Address enable high while DMA owns bus
// - Address latch enable marks valid address
// - Acknowledge low for granted DMA channel
// - Retry output active when distributed DMA
// - Extension write pulses strobe, drives bytes
// - Ready low extends current cycle
// - 16-bit select sizes the cycle
// - Slot master input means master cycle
// - Slot address from PCI; input during master
// - Byte-high enable when upper byte used
// - Low-memory strobes only below 1 Mbyte
// - Memory or I/O strobes per cycle type
// - Bus clock divides link clock by divisor
// - Zero-wait input ends cycle without waits
// - Terminal count when DMA count reached
// - Refresh output marks refresh cycle
// - PCI interrupts level low, optionally mapped
// - Two serial lines exchange link information
// - Request bus, arbiter answers with grant
// - Reset state while reset asserted
// - Map bit selects PCI or mappable format
`timescale 1ns/1ps
`include "pib_regs.vh"
module pib_bridge (
   input wire CLK_SYS_I,
   input wire SRST_I,
   input wire SERIAL_LINK_CLOCK_I,
   input wire [`PIB_DIV_W-1:0] AT_BUS_CONFIG_ONE_DIV_I,
   input wire [`PIB_ADDR_W-1:0] CYC_ADDR_I,
   input wire [3:0] CYC_BE_N_I,
   input wire CYC_IS_MEM_I,
   input wire CYC_WRITE_I,
   input wire [`PIB_DATA_W-1:0] CYC_WDATA_I,
   input wire CYC_REFRESH_I,
   input wire CYC_VALID_I,
   output wire CYC_READY_O,
   output wire [`PIB_DATA_W-1:0] CYC_RDATA_O,
   output wire CYC_DONE_O,
   input wire EXT_LOW_WR_I,
   input wire EXT_HIGH_WR_I,
   input wire [7:0] EXT_DATA_I,
   input wire DDMA_EN_I,
   input wire DDMA_HIT_I,
   input wire [`PIB_CHAN_N-1:0] DRQ_I,
   input wire [`PIB_TC_W-1:0] DMA_COUNT_I,
   input wire MASTER_N_I,
   input wire IOCHRDY_I,
   input wire IOCS16_N_I,
   input wire MEMCS16_N_I,
   input wire ZWS_N_I,
   input wire [`PIB_DATA_W-1:0] SD_I,
   input wire [`PIB_ADDR_W-1:0] SA_I,
   input wire [3:0] PCI_INT_N_I,
   input wire [3:0] INTERRUPT_MAP_SEL_I,
   output reg [3:0] MAPPABLE_INTERRUPT_O,
   output wire [3:0] PCI_INT_ACTIVE_O,
   input wire SERIAL_IN_FROM_HOST_I,
   output reg SERIAL_OUT_TO_HOST_O,
   output reg [`PIB_SER_W-1:0] HOST_WORD_O,
   input wire [`PIB_SER_W-1:0] STATUS_WORD_I,
   input wire BRIDGE_BUS_GRANT_N_I,
   output reg BRIDGE_BUS_REQUEST_N_O,
   output reg AEN_O,
   output reg BALE_O,
   output reg [`PIB_CHAN_N-1:0] DACK_N_O,
   output reg DISTRIBUTED_DMA_RETRY_O,
   output reg OUTPUT_EXTENSION_STROBE_N_O,
   output reg [`PIB_ADDR_W-1:0] SA_O,
   output wire SA_OE_N_O,
   output reg [`PIB_DATA_W-1:0] SD_O,
   output reg SD_OE_N_O,
   output reg SBHE_N_O,
   output reg SMEMR_N_O,
   output reg SMEMW_N_O,
   output reg MEMR_N_O,
   output reg MEMW_N_O,
   output reg IOR_N_O,
   output reg IOW_N_O,
   output reg REFRESH_N_O,
   output reg TC_O,
   output reg SYSCLK_O,
   output wire SLOT_MASTER_CYCLE_O
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_CMD = 3'h2;
   localparam ST_END = 3'h3;
   localparam ST_EXT = 3'h4;
   localparam ST_DMA = 3'h5;

   reg [2:0] st_q;
   reg [2:0] cnt_q;
   reg [7:0] ext_hi_q;
   reg [`PIB_DATA_W-1:0] rdata_q;
   reg done_q;
   reg ext_pend_q;
   reg [7:0] ext_lo_q;
   reg [`PIB_CHAN_W-1:0] chan_q;
   reg [`PIB_TC_W-1:0] xfer_q;
   reg [3:0] int_q;
   reg lclk_q1;
   reg lclk_q2;
   reg lclk_q3;
   reg [`PIB_DIV_W-1:0] div_q;
   reg [`PIB_SER_W-1:0] sh_in_q;
   reg [`PIB_SER_W-1:0] sh_out_q;
   reg [2:0] bit_q;
   reg cur_mem_q;
   reg cur_wr_q;
   reg cur_ref_q;
   reg cur_low_q;
   reg cur_hi_q;
   reg [`PIB_DATA_W-1:0] cur_wdata_q;
   wire [42:0] fifo_in;
   wire [42:0] fifo_out;
   wire fifo_valid;
   wire fifo_take;
   wire master;
   wire [`PIB_CHAN_N-1:0] req;
   wire lclk_rise;
   wire lclk_edge;
   wire cyc16;
   wire [1:0] a_lo;

   // ---------------------------------------------------------------
   // Request queue
   // ---------------------------------------------------------------
   assign fifo_in = {CYC_REFRESH_I, CYC_WRITE_I, CYC_IS_MEM_I, CYC_WDATA_I, CYC_ADDR_I[23:2], CYC_BE_N_I[1:0]};
   assign fifo_take = (st_q == ST_IDLE) & ~master & ~ext_pend_q & (req == {`PIB_CHAN_N{1'b0}});
   pib_fifo #(
      .WIDTH(43),
      .DEPTH(`PIB_FIFO_DEPTH),
      .AW(`PIB_FIFO_AW)
   ) u_fifo (
      .clk_i(CLK_SYS_I),
      .srst_i(SRST_I),
      .in_data_i(fifo_in),
      .in_valid_i(CYC_VALID_I),
      .in_ready_o(CYC_READY_O),
      .out_data_o(fifo_out),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_take)
   );

   assign master = ~MASTER_N_I;
   assign SLOT_MASTER_CYCLE_O = master;
   assign SA_OE_N_O = master;
   assign req = DRQ_I & `PIB_CHAN_MASK;
   assign CYC_RDATA_O = rdata_q;
   assign CYC_DONE_O = done_q;
   // 16-bit cycle only if the target claims it
   assign cyc16 = cur_mem_q ? ~MEMCS16_N_I : ~IOCS16_N_I;
   assign a_lo = (fifo_out[1:0] == 2'h3) ? 2'h2 : 2'h0;

   // ---------------------------------------------------------------
   // Slot cycle engine
   // ---------------------------------------------------------------
   always @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 3'h0;
         ext_hi_q <= 8'h00;
         ext_lo_q <= 8'h00;
         ext_pend_q <= 1'b0;
         rdata_q <= 16'h0000;
         done_q <= 1'b0;
         chan_q <= 3'h0;
         xfer_q <= 16'h0000;
         cur_mem_q <= 1'b0;
         cur_wr_q <= 1'b0;
         cur_ref_q <= 1'b0;
         cur_low_q <= 1'b0;
         cur_hi_q <= 1'b0;
         cur_wdata_q <= 16'h0000;
         SA_O <= 24'h000000;
         SD_O <= 16'h0000;
         SD_OE_N_O <= 1'b1;
         AEN_O <= 1'b0;
         BALE_O <= 1'b0;
         DACK_N_O <= 8'hFF;
         OUTPUT_EXTENSION_STROBE_N_O <= 1'b1;
         SBHE_N_O <= 1'b1;
         SMEMR_N_O <= 1'b1;
         SMEMW_N_O <= 1'b1;
         MEMR_N_O <= 1'b1;
         MEMW_N_O <= 1'b1;
         IOR_N_O <= 1'b1;
         IOW_N_O <= 1'b1;
         REFRESH_N_O <= 1'b1;
         TC_O <= 1'b0;
         BRIDGE_BUS_REQUEST_N_O <= 1'b1;
         DISTRIBUTED_DMA_RETRY_O <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         DISTRIBUTED_DMA_RETRY_O <= DDMA_EN_I & DDMA_HIT_I;
         if (EXT_HIGH_WR_I)
         begin
            ext_hi_q <= EXT_DATA_I;
         end
         if (EXT_LOW_WR_I)
         begin
            ext_lo_q <= EXT_DATA_I;
            ext_pend_q <= 1'b1;
         end
         case (st_q)
            ST_IDLE:
            begin
               SD_OE_N_O <= 1'b1;
               TC_O <= 1'b0;
               if (master)
               begin
                  BRIDGE_BUS_REQUEST_N_O <= 1'b0;
                  SD_OE_N_O <= 1'b1;
               end
               else if (req != 8'h00)
               begin
                  BRIDGE_BUS_REQUEST_N_O <= 1'b0;
                  chan_q <= req[0] ? 3'h0 : req[1] ? 3'h1 : req[2] ? 3'h2 : req[3] ? 3'h3 :
                            req[5] ? 3'h5 : req[6] ? 3'h6 : 3'h7;
                  if (~BRIDGE_BUS_GRANT_N_I)
                  begin
                     AEN_O <= 1'b1;
                     st_q <= ST_DMA;
                  end
               end
               else if (ext_pend_q)
               begin
                  OUTPUT_EXTENSION_STROBE_N_O <= 1'b0;
                  SD_O <= {ext_hi_q, ext_lo_q};
                  SD_OE_N_O <= 1'b0;
                  ext_pend_q <= EXT_LOW_WR_I;
                  cnt_q <= `PIB_STROBE_LEN;
                  st_q <= ST_EXT;
               end
               else if (fifo_valid)
               begin
                  BRIDGE_BUS_REQUEST_N_O <= 1'b1;
                  SA_O <= {fifo_out[23:2], a_lo};
                  cur_ref_q <= fifo_out[42];
                  cur_wr_q <= fifo_out[41];
                  cur_mem_q <= fifo_out[40];
                  cur_wdata_q <= fifo_out[39:24];
                  cur_hi_q <= (fifo_out[1:0] != 2'h2);
                  cur_low_q <= (fifo_out[23:20] == `PIB_LOWMEG_TOP);
                  BALE_O <= 1'b1;
                  st_q <= ST_ADDR;
               end
               else
               begin
                  BRIDGE_BUS_REQUEST_N_O <= 1'b1;
               end
            end
            ST_EXT:
            begin
               cnt_q <= cnt_q - 3'h1;
               if (cnt_q == 3'h1)
               begin
                  OUTPUT_EXTENSION_STROBE_N_O <= 1'b1;
                  st_q <= ST_END;
               end
            end
            ST_ADDR:
            begin
               BALE_O <= 1'b0;
               SBHE_N_O <= ~cur_hi_q;
               REFRESH_N_O <= ~cur_ref_q;
               MEMR_N_O <= ~(cur_mem_q & ~cur_wr_q);
               MEMW_N_O <= ~(cur_mem_q & cur_wr_q);
               SMEMR_N_O <= ~(cur_mem_q & ~cur_wr_q & cur_low_q);
               SMEMW_N_O <= ~(cur_mem_q & cur_wr_q & cur_low_q);
               IOR_N_O <= ~(~cur_mem_q & ~cur_wr_q);
               IOW_N_O <= ~(~cur_mem_q & cur_wr_q);
               SD_O <= cur_wdata_q;
               SD_OE_N_O <= ~cur_wr_q;
               cnt_q <= `PIB_WAIT_STATES;
               st_q <= ST_CMD;
            end
            ST_CMD:
            begin
               // Waits shrink for 16-bit targets; ready low always holds
               if (~ZWS_N_I & IOCHRDY_I)
               begin
                  cnt_q <= 3'h0;
                  st_q <= ST_END;
               end
               else if (cnt_q != 3'h0)
               begin
                  cnt_q <= cnt_q - (cyc16 ? 3'h2 > cnt_q ? cnt_q : 3'h2 : 3'h1);
               end
               else if (IOCHRDY_I)
               begin
                  st_q <= ST_END;
               end
               if (st_q == ST_CMD)
               begin
                  rdata_q <= cyc16 ? SD_I : {8'h00, SD_I[7:0]};
               end
            end
            ST_DMA:
            begin
               DACK_N_O <= ~(8'h01 << chan_q);
               xfer_q <= xfer_q + 16'h0001;
               if (xfer_q + 16'h0001 == DMA_COUNT_I)
               begin
                  TC_O <= 1'b1;
                  xfer_q <= 16'h0000;
               end
               if (~req[chan_q] | BRIDGE_BUS_GRANT_N_I)
               begin
                  st_q <= ST_END;
               end
            end
            ST_END:
            begin
               MEMR_N_O <= 1'b1;
               MEMW_N_O <= 1'b1;
               SMEMR_N_O <= 1'b1;
               SMEMW_N_O <= 1'b1;
               IOR_N_O <= 1'b1;
               IOW_N_O <= 1'b1;
               REFRESH_N_O <= 1'b1;
               SBHE_N_O <= 1'b1;
               SD_OE_N_O <= 1'b1;
               DACK_N_O <= 8'hFF;
               AEN_O <= 1'b0;
               TC_O <= 1'b0;
               done_q <= OUTPUT_EXTENSION_STROBE_N_O & (AEN_O == 1'b0);
               st_q <= ST_IDLE;
            end
            default:
            begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupt format
   // ---------------------------------------------------------------
   assign PCI_INT_ACTIVE_O = ~PCI_INT_N_I & ~INTERRUPT_MAP_SEL_I;
   always @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         // Idle level of the pins, so no false edge after reset
         int_q <= 4'hF;
         MAPPABLE_INTERRUPT_O <= 4'h0;
      end
      else
      begin
         int_q <= PCI_INT_N_I;
         // Rising edge, active high, only where mapped
         MAPPABLE_INTERRUPT_O <= PCI_INT_N_I & ~int_q & INTERRUPT_MAP_SEL_I;
      end
   end

   // ---------------------------------------------------------------
   // Link clock sampling, bus clock divider, serial lines
   // ---------------------------------------------------------------
   // Link clock is sampled, so it must run below half the system rate
   assign lclk_rise = lclk_q2 & ~lclk_q3;
   // Both link edges count, so odd divisors still give an even-duty bus clock
   assign lclk_edge = lclk_q2 ^ lclk_q3;
   always @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         lclk_q1 <= 1'b0;
         lclk_q2 <= 1'b0;
         lclk_q3 <= 1'b0;
         div_q <= 3'h0;
         SYSCLK_O <= 1'b0;
         sh_in_q <= 8'h00;
         sh_out_q <= 8'h00;
         bit_q <= 3'h0;
         HOST_WORD_O <= 8'h00;
         SERIAL_OUT_TO_HOST_O <= 1'b0;
      end
      else
      begin
         lclk_q1 <= SERIAL_LINK_CLOCK_I;
         lclk_q2 <= lclk_q1;
         lclk_q3 <= lclk_q2;
         if (lclk_edge)
         begin
            // Divisor 0 treated as 1 to keep the clock running
            if (div_q + 3'h1 >= AT_BUS_CONFIG_ONE_DIV_I)
            begin
               div_q <= 3'h0;
               SYSCLK_O <= ~SYSCLK_O;
            end
            else
            begin
               div_q <= div_q + 3'h1;
            end
         end
         if (lclk_rise)
         begin
            sh_in_q <= {sh_in_q[6:0], SERIAL_IN_FROM_HOST_I};
            SERIAL_OUT_TO_HOST_O <= sh_out_q[7];
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
               HOST_WORD_O <= {sh_in_q[6:0], SERIAL_IN_FROM_HOST_I};
               sh_out_q <= STATUS_WORD_I;
            end
            else
            begin
               sh_out_q <= {sh_out_q[6:0], 1'b0};
            end
         end
      end
   end
endmodule

// >>> logic/pib_fifo.v
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: full/empty from a fill counter
`timescale 1ns/1ps
module pib_fifo #(
   parameter WIDTH = 42,
   parameter DEPTH = 16,
   parameter AW = 4
)(
   input wire clk_i,
   input wire srst_i,
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire out_valid_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready_o = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_q] <= in_data_i;
      end
      if (srst_i)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop & ~push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// >>> logic/pib_regs.vh
// Purpose: constants for the slot-bus bridge pin logic
// Assumes: single 10 MHz system clock
// Notes: all counts in system clock cycles
`ifndef PIB_REGS_VH
`define PIB_REGS_VH
`define PIB_ADDR_W 24
`define PIB_DATA_W 16
`define PIB_LOWMEG_TOP 4'h0
`define PIB_LOWMEG_HI 23
`define PIB_LOWMEG_LO 20
`define PIB_DIV_W 3
`define PIB_DIV_RST 3'h4
`define PIB_WAIT_STATES 3'h3
`define PIB_STROBE_LEN 3'h2
`define PIB_FIFO_DEPTH 16
`define PIB_FIFO_AW 4
`define PIB_CHAN_N 8
`define PIB_CHAN_W 3
`define PIB_CHAN_MASK 8'hEF
`define PIB_TC_W 16
`define PIB_SER_W 8
`endif

// >>> tb/pib_checker.sv
// Purpose: port checks for pib_bridge
// Assumes: one clock, SRST_I sync high
// Notes: bound below the module
`timescale 1ns/1ps
module pib_checker (
   input wire CLK_SYS_I,
   input wire SRST_I,
   input wire DDMA_EN_I,
   input wire DDMA_HIT_I,
   input wire DISTRIBUTED_DMA_RETRY_O,
   input wire MASTER_N_I,
   input wire SA_OE_N_O,
   input wire SLOT_MASTER_CYCLE_O,
   input wire [23:0] SA_O,
   input wire SMEMR_N_O,
   input wire SMEMW_N_O,
   input wire MEMR_N_O,
   input wire MEMW_N_O,
   input wire IOR_N_O,
   input wire IOW_N_O,
   input wire AEN_O,
   input wire [7:0] DACK_N_O,
   input wire BALE_O,
   input wire OUTPUT_EXTENSION_STROBE_N_O,
   input wire SD_OE_N_O,
   input wire [15:0] SD_O,
   input wire TC_O,
   input wire IOCHRDY_I,
   input wire ZWS_N_I
);
   wire idle = MEMR_N_O & MEMW_N_O & IOR_N_O & IOW_N_O;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   // ----
   // Checks
   // ----
   retry_follow_a: assert property (
      $changed(DISTRIBUTED_DMA_RETRY_O) |-> DISTRIBUTED_DMA_RETRY_O == $past(DDMA_EN_I && DDMA_HIT_I))
      else $error("retry out of step");
   addr_release_a: assert property (
      SA_OE_N_O == !MASTER_N_I && SLOT_MASTER_CYCLE_O == !MASTER_N_I)
      else $error("address drive wrong");
   low_meg_a: assert property (
      !(SMEMR_N_O && SMEMW_N_O) |-> SA_O[23:20] == 4'h0 && SMEMR_N_O == MEMR_N_O && SMEMW_N_O == MEMW_N_O)
      else $error("low memory strobe wrong");
   io_mem_a: assert property (
      !AEN_O && !(IOR_N_O && IOW_N_O) |-> MEMR_N_O && MEMW_N_O)
      else $error("io and memory strobes together");
   dack_owner_a: assert property (
      DACK_N_O != 8'hFF |-> AEN_O && DACK_N_O[4] && $onehot(~DACK_N_O))
      else $error("acknowledge without address enable");
   bale_pulse_a: assert property (
      BALE_O |=> !BALE_O)
      else $error("latch enable too long");
   ext_pulse_a: assert property (
      $fell(OUTPUT_EXTENSION_STROBE_N_O) |-> !SD_OE_N_O ##1
      (!OUTPUT_EXTENSION_STROBE_N_O && $stable(SD_O)) ##1 OUTPUT_EXTENSION_STROBE_N_O)
      else $error("extension strobe shape wrong");
   zero_wait_a: assert property (
      !AEN_O && !idle && !ZWS_N_I && IOCHRDY_I |-> ##[1:2] idle)
      else $error("zero wait cycle not ended");
   ready_hold_a: assert property (
      !AEN_O && !idle && !IOCHRDY_I |=> !idle)
      else $error("cycle ended while not ready");
   tc_dma_a: assert property (
      TC_O |-> AEN_O)
      else $error("terminal count outside transfer");
endmodule
bind pib_bridge pib_checker pib_checker_inst (.*);

// >>> tb/pib_slot_model.sv
// Purpose: slot peripheral answering bridge cycles
// Assumes: strobes registered on clk_i
// Notes: released data bus shows a changing pattern
`timescale 1ns/1ps
module pib_slot_model (
   input wire clk_i,
   input wire slow_i,
   input wire zws_i,
   input wire wide_i,
   input wire [3:0] cmd_n_i,
   input wire [23:0] sa_i,
   output wire iochrdy_o,
   output wire cs16_n_o,
   output wire zws_n_o,
   output wire [15:0] sd_o
);
   reg [2:0] cnt_q = 3'h0;
   reg tog_q = 1'b0;
   wire act = ~&cmd_n_i;
   always @(posedge clk_i)
   begin
      tog_q <= !tog_q;
      cnt_q <= act ? cnt_q + {2'h0, cnt_q != 3'h7} : 3'h0;
   end
   // Slow device stalls four cycles
   assign iochrdy_o = !(act && slow_i && cnt_q < 3'h4);
   assign cs16_n_o = !(act && wide_i);
   assign zws_n_o = !(act && zws_i);
   // Floating bus never holds the last value
   assign sd_o = act ? {~sa_i[15:8], sa_i[15:8]} : {16{tog_q}} ^ 16'hA5C3;
endmodule

// >>> tb/tb_pib_bridge.sv
// Purpose: self-checking bench for pib_bridge
// Assumes: 10 MHz clock, free link clock
// Notes: seed fixed for repeatable runs
`timescale 1ns/1ps
module tb_pib_bridge;
   logic CLK_SYS_I = 0, SRST_I = 1, SERIAL_LINK_CLOCK_I = 0, CYC_IS_MEM_I = 0, CYC_WRITE_I = 0;
   logic CYC_REFRESH_I = 0, CYC_VALID_I = 0, EXT_LOW_WR_I = 0, EXT_HIGH_WR_I = 0, DDMA_EN_I = 0;
   logic DDMA_HIT_I = 0, MASTER_N_I = 1, SERIAL_IN_FROM_HOST_I = 0, BRIDGE_BUS_GRANT_N_I = 1;
   logic [2:0] AT_BUS_CONFIG_ONE_DIV_I = 3'h3;
   logic [23:0] CYC_ADDR_I = 0, SA_I = 0;
   logic [15:0] CYC_WDATA_I = 0, DMA_COUNT_I = 16'h0003;
   logic [7:0] EXT_DATA_I = 0, DRQ_I = 0, STATUS_WORD_I = 0, ch;
   logic [3:0] CYC_BE_N_I = 4'hF, PCI_INT_N_I = 4'hF, INTERRUPT_MAP_SEL_I = 0;
   wire IOCHRDY_I, IOCS16_N_I, MEMCS16_N_I, ZWS_N_I, CYC_READY_O, CYC_DONE_O, SERIAL_OUT_TO_HOST_O;
   wire BRIDGE_BUS_REQUEST_N_O, AEN_O, BALE_O, DISTRIBUTED_DMA_RETRY_O, OUTPUT_EXTENSION_STROBE_N_O;
   wire SA_OE_N_O, SD_OE_N_O, SBHE_N_O, SMEMR_N_O, SMEMW_N_O, MEMR_N_O, MEMW_N_O, IOR_N_O, IOW_N_O;
   wire REFRESH_N_O, TC_O, SYSCLK_O, SLOT_MASTER_CYCLE_O;
   wire [15:0] CYC_RDATA_O, SD_I, SD_O;
   wire [3:0] MAPPABLE_INTERRUPT_O, PCI_INT_ACTIVE_O;
   wire [7:0] HOST_WORD_O, DACK_N_O;
   wire [23:0] SA_O;
   logic slow = 0, zws = 0, wide = 0, full, sys_prev;
   logic [31:0] r;
   int failures = 0, samples_checked = 0, seed = 76, links = 0, dones = 0;
   int k, n, n0, n1, n2, n3, pushes, d0;
   pib_bridge pib_bridge_inst (.*);
   pib_slot_model pib_slot_model_inst (.clk_i(CLK_SYS_I), .slow_i(slow), .zws_i(zws), .wide_i(wide),
      .cmd_n_i({MEMR_N_O, MEMW_N_O, IOR_N_O, IOW_N_O}), .sa_i(SA_O), .iochrdy_o(IOCHRDY_I),
      .cs16_n_o(IOCS16_N_I), .zws_n_o(ZWS_N_I), .sd_o(SD_I));
   assign MEMCS16_N_I = IOCS16_N_I;
   // ----
   // Clocks and background stimulus
   // ----
   initial
   begin
      forever #50 CLK_SYS_I = ~CLK_SYS_I;
   end
   initial
   begin
      #20;
      forever #250 SERIAL_LINK_CLOCK_I = ~SERIAL_LINK_CLOCK_I;
   end
   always @(posedge SERIAL_LINK_CLOCK_I) links <= links + 1;
   always @(posedge CLK_SYS_I) dones <= dones + CYC_DONE_O;
   always @(negedge CLK_SYS_I)
   begin
      BRIDGE_BUS_GRANT_N_I <= BRIDGE_BUS_REQUEST_N_O;
      SERIAL_IN_FROM_HOST_I <= $random(seed);
      STATUS_WORD_I <= $random(seed);
      SA_I <= $random(seed);
   end
   // ----
   // Helpers
   // ----
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task end_of_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic bit cond(input int c);
      case (c)
         1: return OUTPUT_EXTENSION_STROBE_N_O === 1'b0;
         2: return DACK_N_O !== 8'hFF;
         3: return TC_O === 1'b1;
         4: return AEN_O === 1'b0 && DACK_N_O === 8'hFF;
         5: return MAPPABLE_INTERRUPT_O === 4'h2;
         default: return SYSCLK_O !== sys_prev;
      endcase
   endfunction
   task automatic wait_on(input int c);
      int i;
      for (i = 0; i < 400 && !cond(c); i++)
      begin
         @(posedge CLK_SYS_I);
         #1;
      end
      if (!cond(c))
      begin
         chk("wait", c, 0);
         end_of_test;
      end
   endtask
   function automatic logic [6:0] exp_seen(input logic [23:0] a, input logic [1:0] be, input logic m, w);
      return {m & !w, m & w, !m & !w, !m & w, m & (a[23:20] == 4'h0), be != 2'h2, 1'b0};
   endfunction
   task automatic cyc(input logic [23:0] a, input logic [1:0] be, input logic m, w, f, output int low);
      int i;
      logic [6:0] seen;
      seen = 0;
      low = 0;
      @(negedge CLK_SYS_I);
      {CYC_ADDR_I, CYC_BE_N_I, CYC_IS_MEM_I, CYC_WRITE_I, CYC_REFRESH_I} = {a, 2'h3, be, m, w, f};
      CYC_WDATA_I = $random(seed);
      CYC_VALID_I = 1;
      @(negedge CLK_SYS_I);
      CYC_VALID_I = 0;
      for (i = 0; i < 60 && CYC_DONE_O !== 1'b1; i++)
      begin
         @(posedge CLK_SYS_I);
         #1;
         seen |= ~{MEMR_N_O, MEMW_N_O, IOR_N_O, IOW_N_O, SMEMR_N_O & SMEMW_N_O, SBHE_N_O, REFRESH_N_O};
         low += !(MEMR_N_O & MEMW_N_O & IOR_N_O & IOW_N_O);
         if (BALE_O)
            chk("address", a[23:2], SA_O[23:2]);
      end
      chk("done", 1, CYC_DONE_O);
      if (f)
         chk("refresh", 1, seen[0]);
      else
         chk("strobes", exp_seen(a, be, m, w), seen);
      if (wide && !w)
         chk("read data", {~a[15:8], a[15:8]}, CYC_RDATA_O);
   endtask
   // ----
   // Scenarios
   // ----
   initial
   begin
      repeat (20) @(negedge CLK_SYS_I);
      chk("reset", {3'h0, 8'hFF, 5'h1F}, {AEN_O, BALE_O, TC_O, DACK_N_O, BRIDGE_BUS_REQUEST_N_O,
         MEMR_N_O, MEMW_N_O, IOR_N_O, IOW_N_O});
      SRST_I = 0;
      for (k = 0; k < 8; k++)
      begin
         r = $random(seed);
         r[23:20] = k[2] ? 4'h0 : {1'b1, r[22:20]};
         cyc(r[23:0], r[25:24], k[0], k[1], 1'b0, n);
      end
      cyc(r[23:0], 2'h0, 1'b1, 1'b0, 1'b1, n);
      $display("test commands done");
      cyc(24'h000300, 2'h0, 1'b0, 1'b0, 1'b0, n0);
      zws = 1;
      cyc(24'h000300, 2'h0, 1'b0, 1'b0, 1'b0, n1);
      {zws, wide} = 2'b01;
      cyc(24'h000300, 2'h0, 1'b0, 1'b0, 1'b0, n2);
      {wide, slow} = 2'b01;
      cyc(24'h000300, 2'h0, 1'b0, 1'b0, 1'b0, n3);
      slow = 0;
      chk("wait order", 3'h7, {n1 < n0, n2 < n0, n3 > n0});
      $display("test waits done");
      pushes = 0;
      full = 0;
      d0 = dones;
      for (k = 0; k < 40 && !full; k++)
      begin
         @(negedge CLK_SYS_I);
         r = $random(seed);
         {CYC_ADDR_I, CYC_BE_N_I[1:0], CYC_IS_MEM_I, CYC_WRITE_I} = r[27:0];
         full = !CYC_READY_O;
         CYC_VALID_I = !full;
         pushes += !full;
      end
      @(negedge CLK_SYS_I);
      CYC_VALID_I = 0;
      for (k = 0; k < 2000 && dones - d0 < pushes; k++) @(posedge CLK_SYS_I);
      chk("queue full", 1, full && pushes >= 16);
      chk("drained", pushes, dones - d0);
      $display("test queue done");
      @(negedge CLK_SYS_I);
      r = $random(seed);
      EXT_DATA_I = r[15:8];
      EXT_HIGH_WR_I = 1;
      @(negedge CLK_SYS_I);
      {EXT_HIGH_WR_I, EXT_LOW_WR_I, EXT_DATA_I} = {2'b01, r[7:0]};
      @(negedge CLK_SYS_I);
      EXT_LOW_WR_I = 0;
      wait_on(1);
      chk("ext data", {1'b0, r[15:0]}, {SD_OE_N_O, SD_O});
      @(posedge CLK_SYS_I);
      #1 n = OUTPUT_EXTENSION_STROBE_N_O;
      @(posedge CLK_SYS_I);
      #1 chk("ext width", 2'b01, {n[0], OUTPUT_EXTENSION_STROBE_N_O});
      $display("test extension done");
      for (k = 0; k < 8; k++)
         if (k != 4)
         begin
            ch = 8'h01 << k;
            @(negedge CLK_SYS_I);
            DRQ_I = ch | 8'h80;
            wait_on(2);
            chk("dack", 8'hFF ^ ch, DACK_N_O);
            chk("aen req", 2'b10, {AEN_O, BRIDGE_BUS_REQUEST_N_O});
            wait_on(3);
            @(negedge CLK_SYS_I);
            DRQ_I = 0;
            wait_on(4);
         end
      $display("test dma done");
      for (k = 0; k < 4; k++)
      begin
         @(negedge CLK_SYS_I);
         {DDMA_EN_I, DDMA_HIT_I} = k[1:0];
         @(posedge CLK_SYS_I);
         #1 chk("retry", k == 3, DISTRIBUTED_DMA_RETRY_O);
      end
      @(negedge CLK_SYS_I);
      MASTER_N_I = 0;
      #1 chk("master", 2'b11, {SA_OE_N_O, SLOT_MASTER_CYCLE_O});
      @(negedge CLK_SYS_I);
      MASTER_N_I = 1;
      #1 chk("slave", 2'b00, {SA_OE_N_O, SLOT_MASTER_CYCLE_O});
      r = $random(seed);
      PCI_INT_N_I = r[3:0];
      #1 chk("pci int", 4'hF ^ r[3:0], PCI_INT_ACTIVE_O);
      @(negedge CLK_SYS_I);
      {INTERRUPT_MAP_SEL_I, PCI_INT_N_I} = 8'hFD;
      @(negedge CLK_SYS_I);
      PCI_INT_N_I = 4'hF;
      wait_on(5);
      $display("test misc done");
      for (k = 3; k < 5; k++)
      begin
         @(negedge CLK_SYS_I);
         AT_BUS_CONFIG_ONE_DIV_I = k;
         sys_prev = SYSCLK_O;
         wait_on(6);
         sys_prev = SYSCLK_O;
         wait_on(6);
         n = links;
         sys_prev = SYSCLK_O;
         wait_on(6);
         sys_prev = SYSCLK_O;
         wait_on(6);
         chk("bus clock", k, links - n);
      end
      $display("test bus clock done");
      end_of_test;
   end
endmodule
